// ---- core/cell_balance_pkg.sv ----
package cell_balance_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_BAL_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BAL_TIME = 8'h04;
  localparam logic [7:0] ADDR_DEV_STATUS = 8'h08;
  localparam logic [7:0] ADDR_FAULT_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_ADDR_CTRL = 8'h10;
  localparam logic [7:0] ADDR_RESET = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h20;

  // ----------------------------------------------------------------
  // fields and codes
  // ----------------------------------------------------------------
  localparam int NUM_GATES = 6;
  localparam int UNIT_BIT = 7;
  localparam int DS_TIMER_ACTIVE = 0;
  localparam int DS_LOCKOUT = 1;
  localparam int FS_POR = 0;
  localparam int ADDR_VALID_BIT = 7;
  localparam logic [7:0] RESET_CODE = 8'hA5;
  localparam logic [7:0] BROADCAST_ADDR = 8'h3F;
  localparam logic [7:0] BAL_CTRL_RESET = 8'h00;
  localparam logic [7:0] BAL_TIME_RESET = 8'h00;
  localparam int IRQ_EXPIRED = 0;
  localparam int IRQ_LOCKOUT = 1;
  localparam int IRQ_POR = 2;
  localparam int IRQ_BITS = 3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLOCK_HZ = 20_000_000;
  localparam int SECOND_MS = 1000;
  localparam int SECOND_CYCLES = CLOCK_HZ / 1000 * SECOND_MS;
  localparam int SECONDS_PER_MINUTE = 60;
  localparam int LOCKOUT_FILTER_US = 100;
  localparam int LOCKOUT_FILTER_CYCLES =
    (LOCKOUT_FILTER_US * (CLOCK_HZ / 1_000_000));
  localparam int POR_HOLD_US = 5000;
  localparam int POR_HOLD_CYCLES = POR_HOLD_US * (CLOCK_HZ / 1_000_000);
  localparam int CMD_HOLD_US = 300;
  localparam int CMD_HOLD_CYCLES = CMD_HOLD_US * (CLOCK_HZ / 1_000_000);

  // ----------------------------------------------------------------
  // bus carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } wb_req_s;

endpackage : cell_balance_pkg

// ---- core/supply_filter.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------------
// level filter: output follows input after it held for N cycles
// ------------------------------------------------------------------
module supply_filter
  #(
    parameter int HOLD = 2000
  )
  (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_level,
    output logic o_level
  );

  logic [31:0] count;

  // a short glitch restarts the count, so only steady levels pass
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      count <= '0;
      o_level <= 1'b0;
    end
    else if (i_level == o_level)
      count <= '0;
    else if (count >= 32'(HOLD - 1))
    begin
      count <= '0;
      o_level <= i_level;
    end
    else
      count <= count + 32'd1;
  end

endmodule : supply_filter

// ---- core/cell_balance_timer_control.sv ----
`timescale 1ns/1ps
module cell_balance_timer_control
  import cell_balance_pkg::*;
  #(
    parameter int SEC_CYCLES = SECOND_CYCLES,
    parameter int POR_CYCLES = POR_HOLD_CYCLES,
    parameter int CMD_CYCLES = CMD_HOLD_CYCLES,
    parameter int FILTER_CYCLES = LOCKOUT_FILTER_CYCLES,
    parameter int MINUTE_SECS = SECONDS_PER_MINUTE
  )
  (
    input wire logic I_CLOCK,
    input wire logic I_SYS_RST,
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [7:0] I_WB_ADR,
    input wire logic [31:0] I_WB_DAT,
    input wire logic I_SUPPLY_LOW,
    input wire logic I_SUPPLY_POR,
    output logic [31:0] O_WB_DAT,
    output logic O_WB_ACK,
    output logic [NUM_GATES-1:0] O_BALANCE_GATE_OUTPUTS,
    output logic O_IRQ,
    output logic O_IN_RESET
  );

  typedef enum logic [1:0] {RUN, HOLD_POR, HOLD_CMD} rst_state_e;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  wb_req_s req;
  rst_state_e rst_state;
  logic [31:0] hold_count;
  logic [7:0] balance_control_reg;
  logic [7:0] balance_safety_period;
  logic [7:0] addr_ctrl;
  logic address_valid;
  logic balance_timer_active;
  logic low_supply_lockout;
  logic por_flag;
  logic [31:0] prescale;
  logic [5:0] minute_count;
  logic [7:0] remaining;
  logic [IRQ_BITS-1:0] irq_status;
  logic [IRQ_BITS-1:0] irq_enable;
  logic lockout_filt;
  logic por_filt;
  logic lockout_q;
  logic in_reset;
  logic [NUM_GATES-1:0] next_gates;

  // ----------------------------------------------------------------
  // address decode, shared by the write strobes and the read mux
  // ----------------------------------------------------------------
  // full byte compare: a near miss must never alias a real register
  function automatic logic hit(input logic [7:0] adr,
    input logic [7:0] offset);
    return (adr == offset);
  endfunction : hit

  assign req = '{I_WB_CYC, I_WB_STB, I_WB_WE, I_WB_SEL, I_WB_ADR,
                 I_WB_DAT};

  // ----------------------------------------------------------------
  // supply filters
  // ----------------------------------------------------------------
  // both levels share one filter time, so neither reacts to a dip
  supply_filter #(.HOLD(FILTER_CYCLES)) u_low_filter
  (
    .i_clk(I_CLOCK),
    .i_rst(I_SYS_RST),
    .i_level(I_SUPPLY_LOW),
    .o_level(lockout_filt)
  );

  supply_filter #(.HOLD(FILTER_CYCLES)) u_por_filter
  (
    .i_clk(I_CLOCK),
    .i_rst(I_SYS_RST),
    .i_level(I_SUPPLY_POR),
    .o_level(por_filt)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire bus_req = req.cyc && req.stb && !O_WB_ACK;
  wire wr = bus_req && req.we && req.sel[0] && !in_reset;
  wire wr_ctrl = wr && hit(req.adr, ADDR_BAL_CTRL);
  wire wr_time = wr && hit(req.adr, ADDR_BAL_TIME);
  wire wr_fault = wr && hit(req.adr, ADDR_FAULT_STATUS);
  wire wr_addr = wr && hit(req.adr, ADDR_ADDR_CTRL);
  wire wr_iclr = wr && hit(req.adr, ADDR_IRQ_CLEAR);
  wire wr_ien = wr && hit(req.adr, ADDR_IRQ_ENABLE);
  // reset register has no address filter, so broadcast also works
  wire cmd_reset = wr && hit(req.adr, ADDR_RESET) &&
                   (req.dat[7:0] == RESET_CODE);
  wire [7:0] new_ctrl = req.dat[7:0];
  wire new_nonzero = |new_ctrl[NUM_GATES-1:0];
  wire old_nonzero = |balance_control_reg[NUM_GATES-1:0];
  // same level as the control write gate, else a write on lockout
  // exit would store enables with no timer behind them
  wire restart = wr_ctrl && new_nonzero && !old_nonzero
                 && !lockout_filt;
  wire stop_by_host = wr_ctrl && !new_nonzero;

  // ----------------------------------------------------------------
  // tick generation
  // ----------------------------------------------------------------
  wire sec_tick = (prescale == 32'(SEC_CYCLES - 1));
  wire unit_minutes = balance_control_reg[UNIT_BIT];
  wire min_done = (minute_count == 6'(MINUTE_SECS - 1));
  wire unit_tick = sec_tick && (!unit_minutes || min_done);
  wire expire = balance_timer_active && unit_tick &&
                (remaining == 8'd1);

  // read mux
  wire [31:0] rd_data =
    hit(req.adr, ADDR_BAL_CTRL) ? {24'h0, balance_control_reg} :
    hit(req.adr, ADDR_BAL_TIME) ? {24'h0, balance_safety_period} :
    hit(req.adr, ADDR_DEV_STATUS) ?
      {30'h0, low_supply_lockout, balance_timer_active} :
    hit(req.adr, ADDR_FAULT_STATUS) ? {31'h0, por_flag} :
    hit(req.adr, ADDR_ADDR_CTRL) ?
      {24'h0, address_valid, addr_ctrl[6:0]} :
    hit(req.adr, ADDR_IRQ_STATUS) ? {29'h0, irq_status} :
    hit(req.adr, ADDR_IRQ_ENABLE) ? {29'h0, irq_enable} :
    32'h0000_0000;

  // ----------------------------------------------------------------
  // reset sequencer: power-on hold and shortened command hold
  // ----------------------------------------------------------------
  // a supply reset outranks the command; the command hold is short so
  // software has the device back after a few hundred microseconds
  assign in_reset = (rst_state != RUN);
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
    begin
      rst_state <= HOLD_POR;
      hold_count <= '0;
    end
    else if (por_filt)
    begin
      rst_state <= HOLD_POR;
      hold_count <= '0;
    end
    else if (cmd_reset)
    begin
      rst_state <= HOLD_CMD;
      hold_count <= '0;
    end
    else
    begin
      unique case (rst_state)
        RUN: hold_count <= '0;
        HOLD_POR:
        begin
          hold_count <= hold_count + 32'd1;
          if (hold_count >= 32'(POR_CYCLES - 1))
            rst_state <= RUN;
        end
        HOLD_CMD:
        begin
          hold_count <= hold_count + 32'd1;
          if (hold_count >= 32'(CMD_CYCLES - 1))
            rst_state <= RUN;
        end
        // an unused code falls back to the long hold, the safe side
        default: rst_state <= HOLD_POR;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers written by software
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST || in_reset)
    begin
      balance_control_reg <= BAL_CTRL_RESET;
      balance_safety_period <= BAL_TIME_RESET;
      addr_ctrl <= 8'h00;
      address_valid <= 1'b0;
      irq_enable <= '0;
    end
    else
    begin
      // lockout entry wins over a host write landing in the same cycle
      if (lockout_filt && !lockout_q)
        balance_control_reg <= 8'h00;
      else if (wr_ctrl && !lockout_filt)
        balance_control_reg <= new_ctrl;
      if (wr_time)
        balance_safety_period <= req.dat[7:0];
      // address 0 is never a valid own address; the broadcast code only when written with bit 7 clear
      if (wr_addr)
      begin
        addr_ctrl <= req.dat[7:0];
        address_valid <= (req.dat[6:0] != 7'h00) &&
                         (req.dat[7:0] != BROADCAST_ADDR);
      end
      if (wr_ien)
        irq_enable <= req.dat[IRQ_BITS-1:0];
    end
  end

  // ----------------------------------------------------------------
  // safety timer
  // ----------------------------------------------------------------
  // the prescaler only runs while armed, so a restart always gives a
  // full first second; error is one clock period per start
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST || in_reset || lockout_filt)
    begin
      balance_timer_active <= 1'b0;
      remaining <= 8'h00;
      prescale <= '0;
      minute_count <= '0;
    end
    else if (restart)
    begin
      // full period from the start, seconds phase realigned
      balance_timer_active <= (balance_safety_period != 8'h00);
      remaining <= balance_safety_period;
      prescale <= '0;
      minute_count <= '0;
    end
    // prescaler phase is left as is; the next restart realigns it
    else if (stop_by_host || expire)
    begin
      balance_timer_active <= 1'b0;
      remaining <= 8'h00;
    end
    else if (balance_timer_active)
    begin
      prescale <= sec_tick ? 32'd0 : prescale + 32'd1;
      // minutes reuse the seconds tick, so both units share one divider
      if (sec_tick)
        minute_count <= (min_done || !unit_minutes) ? 6'd0 :
                        minute_count + 6'd1;
      if (unit_tick)
        remaining <= remaining - 8'd1;
    end
  end

  // ----------------------------------------------------------------
  // flags: lockout, latched reset flag
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
    begin
      lockout_q <= 1'b0;
      low_supply_lockout <= 1'b0;
      por_flag <= 1'b0;
    end
    else
    begin
      lockout_q <= lockout_filt;
      // status follows the filtered level both ways; no latch needed
      low_supply_lockout <= lockout_filt;
      // set beats clear: held while the hold runs
      if (in_reset)
        por_flag <= 1'b1;
      else if (wr_fault && req.dat[FS_POR])
        por_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status, clear and enable
  // ----------------------------------------------------------------
  wire [IRQ_BITS-1:0] irq_events =
    {in_reset, lockout_filt && !lockout_q, expire};
  wire [IRQ_BITS-1:0] irq_clr = wr_iclr ? req.dat[IRQ_BITS-1:0] : '0;
  // set wins over a same-cycle clear, so no event is ever lost
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
      irq_status <= '0;
    else
      irq_status <= (irq_status & ~irq_clr) | irq_events;
  end

  // ----------------------------------------------------------------
  // outputs, all registered
  // ----------------------------------------------------------------
  // gates need a running timer; lockout and reset hold them low
  wire gate_ok = balance_timer_active && (remaining != 8'h00) &&
                 !expire && !lockout_filt && !in_reset;

  // per-gate drive: each pin copies its own enable bit when permitted
  for (genvar g = 0; g < NUM_GATES; g++)
  begin : g_gate
    assign next_gates[g] = gate_ok && balance_control_reg[g];
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
    begin
      O_BALANCE_GATE_OUTPUTS <= '0;
      O_IRQ <= 1'b0;
      O_IN_RESET <= 1'b1;
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= '0;
    end
    else
    begin
      O_BALANCE_GATE_OUTPUTS <= next_gates;
      O_IRQ <= |(irq_status & irq_enable);
      O_IN_RESET <= in_reset;
      // ack is registered, so a strobe held through ack is taken once
      // port is dead while the power-on hold runs
      O_WB_ACK <= bus_req && (rst_state != HOLD_POR);
      O_WB_DAT <= (bus_req && !req.we) ? rd_data : 32'h0;
    end
  end

endmodule : cell_balance_timer_control

// ---- verif/cell_balance_timer_control_chk.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checker for the balance timer block
// ----------------------------------------------------------------
module cell_balance_timer_control_chk
  import cell_balance_pkg::*;
  #(
    parameter int SEC_CYCLES = SECOND_CYCLES,
    parameter int POR_CYCLES = POR_HOLD_CYCLES,
    parameter int CMD_CYCLES = CMD_HOLD_CYCLES,
    parameter int FILTER_CYCLES = LOCKOUT_FILTER_CYCLES,
    parameter int MINUTE_SECS = SECONDS_PER_MINUTE
  )
  (
    input wire logic I_CLOCK,
    input wire logic I_SYS_RST,
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [7:0] I_WB_ADR,
    input wire logic [31:0] I_WB_DAT,
    input wire logic I_SUPPLY_LOW,
    input wire logic I_SUPPLY_POR,
    input wire logic [31:0] O_WB_DAT,
    input wire logic O_WB_ACK,
    input wire logic [NUM_GATES-1:0] O_BALANCE_GATE_OUTPUTS,
    input wire logic O_IRQ,
    input wire logic O_IN_RESET
  );
  // longest legal run: 255 minutes; longint since defaults overflow int
  localparam longint ON_MAX = 64'(255 * MINUTE_SECS) * SEC_CYCLES + 8;
  int low_n, por_n, hold_n;
  longint on_n;

  // run lengths; a hold under a live supply fault is not counted
  always_ff @(posedge I_CLOCK)
  begin
    if (I_SYS_RST)
    begin
      low_n <= 0;
      por_n <= 0;
      hold_n <= 0;
      on_n <= 0;
    end
    else
    begin
      low_n <= I_SUPPLY_LOW ? low_n + 1 : 0;
      por_n <= I_SUPPLY_POR ? por_n + 1 : 0;
      hold_n <= (O_IN_RESET && !I_SUPPLY_POR) ? hold_n + 1 : 0;
      on_n <= (|O_BALANCE_GATE_OUTPUTS) ? on_n + 1 : 0;
    end
  end

  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_SYS_RST);

  AST_ACK_PULSE: assert property (
    O_WB_ACK |=> !O_WB_ACK) else $error("ack held too long");
  AST_BUS_ANSWERS: assert property (
    I_WB_CYC && I_WB_STB && !O_WB_ACK && !O_IN_RESET && por_n == 0
    |=> O_WB_ACK) else $error("request not answered");
  AST_HOLD_NO_ACK: assert property (
    O_IN_RESET && $past(O_IN_RESET) |-> !O_WB_ACK)
    else $error("ack during reset hold");
  AST_HOLD_GATES_OFF: assert property (
    O_IN_RESET && $past(O_IN_RESET) |-> O_BALANCE_GATE_OUTPUTS == '0)
    else $error("gates on during reset hold");
  AST_POR_ENTERS: assert property (
    por_n > FILTER_CYCLES + 4 |-> O_IN_RESET)
    else $error("low supply did not reset");
  AST_LOCKOUT_OFF: assert property (
    low_n > FILTER_CYCLES + 4 |-> O_BALANCE_GATE_OUTPUTS == '0)
    else $error("gates on in lockout");
  AST_HOLD_BOUND: assert property (
    hold_n <= POR_CYCLES + FILTER_CYCLES + 6)
    else $error("reset hold too long");
  AST_GATE_RISE: assert property (
    |(O_BALANCE_GATE_OUTPUTS & ~$past(O_BALANCE_GATE_OUTPUTS))
    |-> $past(O_WB_ACK) || O_WB_ACK ##0 $past(I_WB_WE)
    && $past(I_WB_ADR) == ADDR_BAL_CTRL)
    else $error("gate rose without control write");
  AST_EXPIRY_BOUND: assert property (
    on_n <= ON_MAX) else $error("gates outlived the timer");

  COV_EXPIRY: cover property ($fell(|O_BALANCE_GATE_OUTPUTS));
  COV_LOCKOUT: cover property (low_n == FILTER_CYCLES + 5);
  COV_HOLD_END: cover property ($fell(O_IN_RESET));
endmodule : cell_balance_timer_control_chk

bind cell_balance_timer_control cell_balance_timer_control_chk #(
  .SEC_CYCLES(SEC_CYCLES), .POR_CYCLES(POR_CYCLES),
  .CMD_CYCLES(CMD_CYCLES), .FILTER_CYCLES(FILTER_CYCLES),
  .MINUTE_SECS(MINUTE_SECS)) chk (.*);

// ---- verif/balance_fet_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// balancing transistors, one per cell
// ----------------------------------------------------------------
module balance_fet_model
  (
    input wire logic [5:0] i_gates,
    output logic [5:0] o_conducting
  );
  // only a solid high turns a transistor on; a floating gate is off
  always_comb
  begin
    for (int k = 0; k < 6; k++)
      o_conducting[k] = (i_gates[k] === 1'b1);
  end
endmodule : balance_fet_model

// ---- verif/cell_balance_timer_control_test.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// bench: bus tasks, model values, scenarios
// ----------------------------------------------------------------
module cell_balance_timer_control_test;
  import cell_balance_pkg::*;
  localparam int SEC = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic low = 1'b0;
  logic por = 1'b0;
  wb_req_s req = '0;
  logic [31:0] rd, odat;
  logic ack, irq, inrst;
  logic [5:0] gates, fets;
  int mismatches = 0;
  int n_compared = 0;
  int cnt = 0;
  int m_ctrl, t0, ex;

  cell_balance_timer_control #(.SEC_CYCLES(SEC), .POR_CYCLES(10),
    .CMD_CYCLES(5), .FILTER_CYCLES(3), .MINUTE_SECS(60)) dut (
    .I_CLOCK(clk), .I_SYS_RST(rst), .I_WB_CYC(req.cyc),
    .I_WB_STB(req.stb), .I_WB_WE(req.we), .I_WB_SEL(req.sel),
    .I_WB_ADR(req.adr), .I_WB_DAT(req.dat), .I_SUPPLY_LOW(low),
    .I_SUPPLY_POR(por), .O_WB_DAT(odat), .O_WB_ACK(ack),
    .O_BALANCE_GATE_OUTPUTS(gates), .O_IRQ(irq), .O_IN_RESET(inrst));
  balance_fet_model fet (.i_gates(gates), .o_conducting(fets));

  // clock, and a cycle count for timer windows
  initial forever #25 clk = ~clk;
  always @(posedge clk) cnt <= cnt + 1;

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  task automatic timeout;
    $display("unexpected at %0t: wait ran out", $time);
    mismatches++;
    finish_test();
  endtask : timeout

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  // one classic cycle; ack is read as it stood before the edge
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [7:0] d);
    int n;
    n = 0;
    req <= '{1'b1, 1'b1, w, 4'hF, a, {24'h0, d}};
    do
    begin
      @(posedge clk);
      n++;
      if (n > 40)
        timeout();
    end
    while (ack !== 1'b1);
    rd = odat;
    req <= '0;
    @(posedge clk);
  endtask : bus

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check(rd, {24'h0, e});
  endtask : rdchk

  task automatic wait_ready;
    int n;
    n = 0;
    while (inrst !== 1'b0)
    begin
      @(posedge clk);
      n++;
      if (n > 200)
        timeout();
    end
  endtask : wait_ready

  task automatic wait_off;
    int n;
    n = 0;
    while (gates !== 6'h00)
    begin
      @(posedge clk);
      n++;
      if (n > 2000)
        timeout();
    end
  endtask : wait_off

  // main sequence
  initial
  begin
    void'($urandom(32'h8EE3));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wait_ready();
    rdchk(ADDR_BAL_CTRL, 8'h00);
    rdchk(ADDR_FAULT_STATUS, 8'h01);
    rdchk(ADDR_ADDR_CTRL, 8'h00);
    rdchk(8'h3C, 8'h00);
    bus(1'b1, ADDR_FAULT_STATUS, 8'h00);
    rdchk(ADDR_FAULT_STATUS, 8'h01);
    bus(1'b1, ADDR_FAULT_STATUS, 8'h01);
    rdchk(ADDR_FAULT_STATUS, 8'h00);
    rdchk(ADDR_IRQ_STATUS, 8'h04);
    check(32'(irq), 32'h0);
    bus(1'b1, ADDR_IRQ_ENABLE, 8'h07);
    check(32'(irq), 32'h1);
    bus(1'b1, ADDR_IRQ_CLEAR, 8'h04);
    check(32'(irq), 32'h0);
    bus(1'b1, ADDR_BAL_CTRL, 8'h01);
    check(32'(gates), 32'h0);
    bus(1'b1, ADDR_BAL_CTRL, 8'h00);
    $display("flags and zero period done");
    // 0: change kept, 1: cleared then set restarts, 2: minutes
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b1, ADDR_BAL_TIME, (i == 2) ? 8'h01 : 8'h02);
      ex = (i == 2) ? 60 * SEC : 2 * SEC;
      m_ctrl = $urandom_range(63, 1);
      bus(1'b1, ADDR_BAL_CTRL, {i == 2, 1'b0, m_ctrl[5:0]});
      t0 = cnt;
      check(32'(gates), m_ctrl);
      rdchk(ADDR_DEV_STATUS, 8'h01);
      repeat (15) @(posedge clk);
      if (i == 1)
      begin
        bus(1'b1, ADDR_BAL_CTRL, 8'h00);
        check(32'(gates), 32'h0);
        rdchk(ADDR_DEV_STATUS, 8'h00);
      end
      m_ctrl = m_ctrl % 63 + 1;
      bus(1'b1, ADDR_BAL_CTRL, {i == 2, 1'b0, m_ctrl[5:0]});
      if (i == 1)
        t0 = cnt;
      check(32'(fets), m_ctrl);
      wait_off();
      t0 = cnt - t0;
      check(32'(t0 >= ex * 9 / 10 - 4 && t0 <= ex * 11 / 10 + 4), 1);
      rdchk(ADDR_DEV_STATUS, 8'h00);
      check(32'({fets, irq}), 32'h1);
      bus(1'b1, ADDR_IRQ_CLEAR, 8'h01);
      // expiry keeps the enables; zero them so the next start restarts
      bus(1'b1, ADDR_BAL_CTRL, 8'h00);
    end
    $display("safety timer done");
    bus(1'b1, ADDR_BAL_TIME, 8'h05);
    bus(1'b1, ADDR_BAL_CTRL, 8'h3F);
    low <= 1'b1;
    repeat (10) @(posedge clk);
    check(32'(gates), 32'h0);
    rdchk(ADDR_BAL_CTRL, 8'h00);
    rdchk(ADDR_DEV_STATUS, 8'h02);
    rdchk(ADDR_BAL_TIME, 8'h05);
    rdchk(ADDR_IRQ_STATUS, 8'h02);
    check(32'(irq), 32'h1);
    bus(1'b1, ADDR_IRQ_CLEAR, 8'h02);
    low <= 1'b0;
    repeat (6) @(posedge clk);
    $display("lockout done");
    bus(1'b1, ADDR_ADDR_CTRL, 8'h05);
    rdchk(ADDR_ADDR_CTRL, 8'h85);
    bus(1'b1, ADDR_BAL_CTRL, 8'h01);
    bus(1'b1, ADDR_RESET, 8'h5A);
    check(32'({gates, inrst}), 32'h2);
    bus(1'b1, ADDR_RESET, RESET_CODE);
    check(32'({gates, inrst}), 32'h1);
    wait_ready();
    rdchk(ADDR_BAL_TIME, 8'h00);
    rdchk(ADDR_ADDR_CTRL, 8'h00);
    rdchk(ADDR_FAULT_STATUS, 8'h01);
    rdchk(ADDR_DEV_STATUS, 8'h00);
    bus(1'b1, ADDR_RESET, RESET_CODE);
    check(32'(inrst), 32'h1);
    wait_ready();
    $display("reset command done");
    bus(1'b1, ADDR_FAULT_STATUS, 8'h01);
    rdchk(ADDR_FAULT_STATUS, 8'h00);
    por <= 1'b1;
    repeat (10) @(posedge clk);
    check(32'(inrst), 32'h1);
    por <= 1'b0;
    wait_ready();
    rdchk(ADDR_FAULT_STATUS, 8'h01);
    $display("supply reset done");
    finish_test();
  end
endmodule : cell_balance_timer_control_test
